// file: design/eab_defs.svh
/*
  Field positions, section bias and bit-processor operation codes for the
  effective address and bit unit. Included by the design modules by bare name.
*/
// Behaviour
// - Direct address ORs program counter top bit.
// - Bias comes from the advanced program counter.
// - Long branch unbiased, unindexed, may be indirect.
// - Long branch bit 16 belongs to opcode.
// - Instruction bit 17 marks an indirect reference.
// - Indirect reference reads an address word.
// - Standard 16-bit and long 18-bit indirect words.
// - Indirect word addresses get no section bias.
// - Indirect word bit 23 chains another fetch.
// - Every indirect level applies its own index.
// - Two-bit selector picks one of three indexes.
// - Upper section indexed references stay upper.
// - Base register loads from third index register.
// - Base plus displacement, bit select, opcode fields.
// - Movement opcodes use bits 23-12 only.
// - Hold bit is operand and destination.
// - Condition register reports each bit operation except base transfers.
// - AND, OR, XOR with memory or complement, negate.
// - Bit transfers, set, clear, base transfers.
// - Queries and conditional branch on selected bit.
// - Display word: base 17-0, hold bit 18.
`ifndef EAB_DEFS_SVH
`define EAB_DEFS_SVH
`define EAB_IND_BIT 17
`define EAB_X_HI 19
`define EAB_X_LO 18
`define EAB_IW_MORE 23
`define EAB_IW_LONG 22
`define EAB_IW_X_HI 21
`define EAB_IW_X_LO 20
`define EAB_BIAS 18'h08000
`define EAB_LAST_BIT 5'h17
`define EAB_C_AND_MEM 11'h700
`define EAB_C_AND_NOTMEM 11'h701
`define EAB_C_OR_MEM 11'h702
`define EAB_C_OR_NOTMEM 11'h703
`define EAB_C_XOR_MEM 11'h704
`define EAB_C_XOR_NOTMEM 11'h705
`define EAB_C_SET_MEM 11'h706
`define EAB_C_CLEAR_MEM 11'h707
`define EAB_C_QUERY_MEM 11'h708
`define EAB_C_HOLD_TO_MEM 11'h709
`define EAB_C_MEM_TO_HOLD 11'h70A
`define EAB_C_BRANCH_BIT 11'h70B
`define EAB_C_NEGATE 12'hE20
`define EAB_C_QUERY_HOLD 12'hE21
`define EAB_C_FLAG_TO_HOLD 12'hE22
`define EAB_C_ZERO_TO_HOLD 12'hE23
`define EAB_C_INDEX_TO_BASE 12'hE24
`define EAB_C_BASE_TO_INDEX 12'hE25
`endif

// file: design/eab_pkg.sv
/*
  Types shared by the effective address and bit unit.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package eab_pkg;
  // Controller states, one-hot.
  typedef enum logic [3:0] {
    EAB_S_IDLE = 4'h1,
    EAB_S_IND = 4'h2,
    EAB_S_BRD = 4'h4,
    EAB_S_BWR = 4'h8
  } eab_state_t;
  // Kind of request from the decoder.
  typedef enum logic [1:0] {
    EAB_K_MEMREF = 2'h0,
    EAB_K_LONGBR = 2'h1,
    EAB_K_BIT = 2'h2
  } eab_kind_t;
  // Bit-processor operations.
  typedef enum logic [4:0] {
    EAB_OP_NONE, EAB_OP_AND_MEM_WITH_HOLD, EAB_OP_AND_NOTMEM_WITH_HOLD,
    EAB_OP_OR_MEM_WITH_HOLD, EAB_OP_OR_NOTMEM_WITH_HOLD, EAB_OP_XOR_MEM_WITH_HOLD,
    EAB_OP_XOR_NOTMEM_WITH_HOLD, EAB_OP_NEGATE_HOLD, EAB_OP_SET_MEM_BIT,
    EAB_OP_CLEAR_MEM_BIT, EAB_OP_QUERY_HOLD_BIT, EAB_OP_QUERY_MEM_BIT,
    EAB_OP_FLAG_TO_HOLD, EAB_OP_HOLD_TO_MEM, EAB_OP_MEM_TO_HOLD,
    EAB_OP_ZERO_TO_HOLD, EAB_OP_INDEX_TO_BASE, EAB_OP_BASE_TO_INDEX,
    EAB_OP_BRANCH_ON_BIT
  } eab_bop_t;
  // The three index registers as seen from the CPU.
  typedef struct packed {
    logic [23:0] i;
    logic [23:0] j;
    logic [23:0] k;
  } eab_idx_t;
  // Memory request carrier.
  typedef struct packed {
    logic req;
    logic we;
    logic [17:0] addr;
    logic [23:0] wdata;
  } eab_mem_t;
  // Whole state of the top module.
  typedef struct packed {
    eab_state_t state;
    eab_mem_t mem;
    eab_bop_t op;
    logic [23:0] instr;
    logic [17:0] ea;
    logic [17:0] bit_base_address;
    logic bit_hold;
    logic [3:0] cond;
    logic done;
    logic cond_vld;
    logic branch;
    logic k_wr;
  } eab_st_t;
endpackage : eab_pkg

// file: design/eab_ea_calc.sv
/*
  Combinational address former: section bias, index add, 18-bit result.
  Assumes the index registers are stable while the result is used.
*/
`timescale 1ns/1ps
`include "eab_defs.svh"
module eab_ea_calc (
  // Address field and modifiers.
  input wire logic [17:0] addr,
  input wire logic [1:0] xsel,
  input wire logic bias_en,
  input wire logic section_bias_bit,
  input wire eab_pkg::eab_idx_t idx,
  // Result.
  output logic [17:0] ea
);
  import eab_pkg::*;
  logic [17:0] based; // Field after optional bias.
  logic [17:0] xval; // Selected index contribution.
  logic up; // Reference is biased into the upper section.

  // Bias, select the index and add, keeping upper references upper.
  always_comb begin
    up = bias_en & section_bias_bit;
    based = up ? (addr | `EAB_BIAS) : addr;
    unique case (xsel)
      2'h1: xval = idx.i[17:0];
      2'h2: xval = idx.j[17:0];
      2'h3: xval = idx.k[17:0];
      default: xval = 18'h00000;
    endcase
    ea = based + xval;
    if (up) begin
      ea = ea | `EAB_BIAS;
    end
  end
endmodule : eab_ea_calc

// file: design/eab_bit_alu.sv
/*
  Combinational single-bit operator on the hold bit and a memory word.
  Assumes the select value numbers bit 0 as the least significant.
*/
`timescale 1ns/1ps
`include "eab_defs.svh"
module eab_bit_alu (
  // Operands.
  input wire eab_pkg::eab_bop_t op,
  input wire logic [23:0] word,
  input wire logic [4:0] sel,
  input wire logic hold,
  input wire logic flag,
  // Results.
  output logic new_hold,
  output logic [23:0] new_word,
  output logic write,
  output logic res
);
  import eab_pkg::*;
  logic m; // Selected memory bit; zero beyond bit 23.
  logic ok; // Select is inside the word.

  // Apply the operation; the hold bit is both operand and destination.
  always_comb begin
    ok = (sel <= `EAB_LAST_BIT);
    m = ok ? word[sel] : 1'b0;
    new_hold = hold;
    new_word = word;
    write = 1'b0;
    unique case (op)
      EAB_OP_AND_MEM_WITH_HOLD: new_hold = hold & m;
      EAB_OP_AND_NOTMEM_WITH_HOLD: new_hold = hold & ~m;
      EAB_OP_OR_MEM_WITH_HOLD: new_hold = hold | m;
      EAB_OP_OR_NOTMEM_WITH_HOLD: new_hold = hold | ~m;
      EAB_OP_XOR_MEM_WITH_HOLD: new_hold = hold ^ m;
      EAB_OP_XOR_NOTMEM_WITH_HOLD: new_hold = hold ^ ~m;
      EAB_OP_NEGATE_HOLD: new_hold = ~hold;
      EAB_OP_MEM_TO_HOLD: new_hold = m;
      EAB_OP_ZERO_TO_HOLD: new_hold = 1'b0;
      EAB_OP_FLAG_TO_HOLD: new_hold = flag;
      EAB_OP_SET_MEM_BIT, EAB_OP_CLEAR_MEM_BIT, EAB_OP_HOLD_TO_MEM: begin
        if (ok) begin
          new_word[sel] = (op == EAB_OP_SET_MEM_BIT) ? 1'b1 :
                          (op == EAB_OP_CLEAR_MEM_BIT) ? 1'b0 : hold;
        end
        write = ok;
      end
      default: new_hold = hold;
    endcase
    // Reported bit: the hold result, or the tested bit for memory queries, bit branches, set and clear.
    unique case (op)
      EAB_OP_QUERY_MEM_BIT, EAB_OP_BRANCH_ON_BIT, EAB_OP_SET_MEM_BIT,
      EAB_OP_CLEAR_MEM_BIT: res = m;
      default: res = new_hold;
    endcase
  end
endmodule : eab_bit_alu

// file: design/eab_unit.sv
/*
  Effective address generator with indirect chains and indexing, plus the
  single-bit processor with its base and hold registers.
  Assumes: start is a one-cycle pulse only while busy is low; memory answers
  each request with a one-cycle mem_ack while the request is held; pc is the
  already advanced program counter; all inputs are synchronous to ref_clk.
*/
`timescale 1ns/1ps
`include "eab_defs.svh"
module eab_unit (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Decoder request.
  input wire logic start,
  input wire eab_pkg::eab_kind_t kind,
  input wire logic [23:0] instr,
  input wire logic [15:0] pc,
  input wire eab_pkg::eab_idx_t idx,
  input wire logic flag,
  // Decoder answer.
  output logic busy,
  output logic done,
  output logic [17:0] ea,
  output logic [3:0] cond,
  output logic cond_vld,
  output logic branch_take,
  output logic k_wr,
  output logic [23:0] k_wdata,
  // Memory port.
  output eab_pkg::eab_mem_t mem,
  input wire logic mem_ack,
  input wire logic [23:0] mem_rdata,
  // Console entry and display.
  input wire logic con_load,
  input wire logic [23:0] con_wdata,
  output logic [23:0] display
);
  import eab_pkg::*;

  // Map instruction code fields to a bit operation.
  function automatic eab_bop_t eab_decode(input logic [23:0] w);
    eab_bop_t op;
    op = EAB_OP_NONE;
    unique case (w[23:13])
      `EAB_C_AND_MEM: op = EAB_OP_AND_MEM_WITH_HOLD;
      `EAB_C_AND_NOTMEM: op = EAB_OP_AND_NOTMEM_WITH_HOLD;
      `EAB_C_OR_MEM: op = EAB_OP_OR_MEM_WITH_HOLD;
      `EAB_C_OR_NOTMEM: op = EAB_OP_OR_NOTMEM_WITH_HOLD;
      `EAB_C_XOR_MEM: op = EAB_OP_XOR_MEM_WITH_HOLD;
      `EAB_C_XOR_NOTMEM: op = EAB_OP_XOR_NOTMEM_WITH_HOLD;
      `EAB_C_SET_MEM: op = EAB_OP_SET_MEM_BIT;
      `EAB_C_CLEAR_MEM: op = EAB_OP_CLEAR_MEM_BIT;
      `EAB_C_QUERY_MEM: op = EAB_OP_QUERY_MEM_BIT;
      `EAB_C_HOLD_TO_MEM: op = EAB_OP_HOLD_TO_MEM;
      `EAB_C_MEM_TO_HOLD: op = EAB_OP_MEM_TO_HOLD;
      `EAB_C_BRANCH_BIT: op = EAB_OP_BRANCH_ON_BIT;
      default: op = EAB_OP_NONE;
    endcase
    unique case (w[23:12])
      `EAB_C_NEGATE: op = EAB_OP_NEGATE_HOLD;
      `EAB_C_QUERY_HOLD: op = EAB_OP_QUERY_HOLD_BIT;
      `EAB_C_FLAG_TO_HOLD: op = EAB_OP_FLAG_TO_HOLD;
      `EAB_C_ZERO_TO_HOLD: op = EAB_OP_ZERO_TO_HOLD;
      `EAB_C_INDEX_TO_BASE: op = EAB_OP_INDEX_TO_BASE;
      `EAB_C_BASE_TO_INDEX: op = EAB_OP_BASE_TO_INDEX;
      default: op = op;
    endcase
    return op;
  endfunction : eab_decode

  // True for operations that need a word from memory.
  function automatic logic eab_needs_mem(input eab_bop_t op);
    return op inside {EAB_OP_AND_MEM_WITH_HOLD, EAB_OP_AND_NOTMEM_WITH_HOLD,
      EAB_OP_OR_MEM_WITH_HOLD, EAB_OP_OR_NOTMEM_WITH_HOLD,
      EAB_OP_XOR_MEM_WITH_HOLD, EAB_OP_XOR_NOTMEM_WITH_HOLD,
      EAB_OP_SET_MEM_BIT, EAB_OP_CLEAR_MEM_BIT, EAB_OP_QUERY_MEM_BIT,
      EAB_OP_HOLD_TO_MEM, EAB_OP_MEM_TO_HOLD, EAB_OP_BRANCH_ON_BIT};
  endfunction : eab_needs_mem

  // Condition code from one reported bit: bit 0 set, bit 1 clear.
  function automatic logic [3:0] eab_cond(input logic b);
    return {2'b00, ~b, b};
  endfunction : eab_cond

  eab_st_t r_reg; // Registered state.
  eab_st_t r_next; // Next state.
  eab_bop_t dec_op; // Operation decoded from the incoming instruction.
  eab_bop_t alu_op; // Operation fed to the bit operator.
  logic in_ind; // Address field comes from a fetched indirect word.
  logic [17:0] calc_addr; // Address field fed to the former.
  logic [1:0] calc_x; // Index selector fed to the former.
  logic calc_bias; // Section bias applies.
  logic [17:0] calc_ea; // Formed effective address.
  logic alu_hold; // Hold bit after the operation.
  logic [23:0] alu_word; // Word after a memory bit change.
  logic alu_write; // Word must be written back.
  logic alu_res; // Bit reported to the condition register.
  logic [17:0] bit_addr; // Base plus displacement.

  // Choose the address source for this cycle.
  always_comb begin
    in_ind = (r_reg.state == EAB_S_IND);
    dec_op = eab_decode(instr);
    alu_op = (r_reg.state == EAB_S_IDLE) ? dec_op : r_reg.op;
    bit_addr = r_reg.bit_base_address + {10'h000, instr[7:0]};
    if (in_ind) begin
      // Long words carry 18 address bits, standard words 16.
      calc_addr = mem_rdata[`EAB_IW_LONG] ? mem_rdata[17:0] :
                  {2'b00, mem_rdata[15:0]};
      calc_x = mem_rdata[`EAB_IW_X_HI:`EAB_IW_X_LO];
      calc_bias = 1'b0;
    end else if (kind == EAB_K_LONGBR) begin
      calc_addr = {2'b00, instr[15:0]};
      calc_x = 2'b00;
      calc_bias = 1'b0;
    end else begin
      calc_addr = {3'b000, instr[14:0]};
      calc_x = instr[`EAB_X_HI:`EAB_X_LO];
      calc_bias = 1'b1;
    end
  end

  // Address former.
  eab_ea_calc u_calc (
    .addr(calc_addr),
    .xsel(calc_x),
    .bias_en(calc_bias),
    .section_bias_bit(pc[15]),
    .idx(idx),
    .ea(calc_ea)
  );

  // Bit operator.
  eab_bit_alu u_alu (
    .op(alu_op),
    .word(mem_rdata),
    .sel(r_reg.instr[12:8]),
    .hold(r_reg.bit_hold),
    .flag(flag),
    .new_hold(alu_hold),
    .new_word(alu_word),
    .write(alu_write),
    .res(alu_res)
  );

  // Controller: sequences indirect chains and bit read-modify-write.
  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    r_next.cond_vld = 1'b0;
    r_next.branch = 1'b0;
    r_next.k_wr = 1'b0;
    unique case (r_reg.state)
      EAB_S_IDLE: begin
        if (start && kind == EAB_K_BIT) begin
          r_next.instr = instr;
          r_next.op = dec_op;
          if (eab_needs_mem(dec_op)) begin
            // Fetch the word holding the selected bit.
            r_next.mem.req = 1'b1;
            r_next.mem.we = 1'b0;
            r_next.mem.addr = bit_addr;
            r_next.state = EAB_S_BRD;
          end else begin
            // Movement operations finish at once.
            r_next.done = 1'b1;
            if (dec_op == EAB_OP_INDEX_TO_BASE) begin
              r_next.bit_base_address = idx.k[17:0];
            end else if (dec_op == EAB_OP_BASE_TO_INDEX) begin
              r_next.k_wr = 1'b1;
            end else if (dec_op != EAB_OP_NONE) begin
              r_next.bit_hold = alu_hold;
              r_next.cond = eab_cond(alu_res);
              r_next.cond_vld = 1'b1;
            end
          end
        end else if (start) begin
          r_next.instr = instr;
          if (instr[`EAB_IND_BIT]) begin
            // Indirect: the formed address holds another address.
            r_next.mem.req = 1'b1;
            r_next.mem.we = 1'b0;
            r_next.mem.addr = calc_ea;
            r_next.state = EAB_S_IND;
          end else begin
            r_next.ea = calc_ea;
            r_next.done = 1'b1;
          end
        end
      end
      EAB_S_IND: begin
        // Hold the request until memory answers.
        if (mem_ack) begin
          if (mem_rdata[`EAB_IW_MORE]) begin
            r_next.mem.addr = calc_ea;
          end else begin
            r_next.mem.req = 1'b0;
            r_next.ea = calc_ea;
            r_next.done = 1'b1;
            r_next.state = EAB_S_IDLE;
          end
        end
      end
      EAB_S_BRD: begin
        if (mem_ack) begin
          r_next.bit_hold = alu_hold;
          r_next.cond = eab_cond(alu_res);
          r_next.branch = (r_reg.op == EAB_OP_BRANCH_ON_BIT) & alu_res;
          if (alu_write) begin
            // Write the changed word back to the same place.
            r_next.mem.we = 1'b1;
            r_next.mem.wdata = alu_word;
            r_next.state = EAB_S_BWR;
          end else begin
            r_next.mem.req = 1'b0;
            r_next.done = 1'b1;
            r_next.cond_vld = 1'b1;
            r_next.state = EAB_S_IDLE;
          end
        end
      end
      EAB_S_BWR: begin
        if (mem_ack) begin
          r_next.mem.req = 1'b0;
          r_next.mem.we = 1'b0;
          r_next.done = 1'b1;
          r_next.cond_vld = 1'b1;
          r_next.state = EAB_S_IDLE;
        end
      end
      default: r_next.state = EAB_S_IDLE;
    endcase
    // Console entry loads base and hold together.
    if (con_load) begin
      r_next.bit_base_address = con_wdata[17:0];
      r_next.bit_hold = con_wdata[18];
    end
  end

  // State register.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      r_reg <= '{state: EAB_S_IDLE, op: EAB_OP_NONE, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from the state register.
  assign busy = (r_reg.state != EAB_S_IDLE);
  assign done = r_reg.done;
  assign ea = r_reg.ea;
  assign cond = r_reg.cond;
  assign cond_vld = r_reg.cond_vld;
  assign branch_take = r_reg.branch;
  assign k_wr = r_reg.k_wr;
  assign k_wdata = {6'h00, r_reg.bit_base_address};
  assign mem = r_reg.mem;
  assign display = {5'h00, r_reg.bit_hold, r_reg.bit_base_address};

  // Checks.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_bias;
    start && !busy && kind == EAB_K_MEMREF && !instr[17] && instr[19:18] == 2'b00
      |=> done && ea == ({3'b000, $past(instr[14:0])} | {2'b00, $past(pc[15]), 15'h0000});
  endproperty
  a_bias: assert property (p_bias) else $error("direct address bias wrong");

  property p_upper;
    start && !busy && kind == EAB_K_MEMREF && !instr[17] && pc[15] |=> done && ea[15];
  endproperty
  a_upper: assert property (p_upper) else $error("upper reference left section");

  property p_long;
    start && !busy && kind == EAB_K_LONGBR && !instr[17]
      |=> done && ea == {2'b00, $past(instr[15:0])};
  endproperty
  a_long: assert property (p_long) else $error("long branch address wrong");

  property p_ind;
    start && !busy && kind != EAB_K_BIT && instr[17]
      |=> r_reg.state == EAB_S_IND && mem.req && !mem.we && !done;
  endproperty
  a_ind: assert property (p_ind) else $error("indirect fetch not issued");

  property p_chain;
    r_reg.state == EAB_S_IND && mem_ack && mem_rdata[23] |=> r_reg.state == EAB_S_IND && mem.req;
  endproperty
  a_chain: assert property (p_chain) else $error("chain ended early");

  property p_end;
    r_reg.state == EAB_S_IND && mem_ack && !mem_rdata[23] && !mem_rdata[22]
      && mem_rdata[21:20] == 2'b00 |=> done && ea == {2'b00, $past(mem_rdata[15:0])} && !busy;
  endproperty
  a_end: assert property (p_end) else $error("chain end address wrong");

  property p_stall;
    r_reg.state == EAB_S_IND && !mem_ack |=> r_reg.state == EAB_S_IND && mem.req && !done;
  endproperty
  a_stall: assert property (p_stall) else $error("did not wait for memory");

  property p_tkv;
    start && !busy && kind == EAB_K_BIT && eab_decode(instr) == EAB_OP_INDEX_TO_BASE && !con_load
      |=> display[17:0] == $past(idx.k[17:0]);
  endproperty
  a_tkv: assert property (p_tkv) else $error("base not loaded from index");

  property p_brd;
    start && !busy && kind == EAB_K_BIT && eab_needs_mem(eab_decode(instr))
      |=> mem.req && mem.addr == $past(r_reg.bit_base_address) + {10'h000, $past(instr[7:0])};
  endproperty
  a_brd: assert property (p_brd) else $error("bit word address wrong");

  property p_level_index;
    r_reg.state == EAB_S_IND && mem_ack && mem_rdata[23] && !mem_rdata[22]
      && mem_rdata[21:20] == 2'b01
      |=> mem.addr == {2'b00, $past(mem_rdata[15:0])} + $past(idx.i[17:0]);
  endproperty
  a_level_index: assert property (p_level_index) else $error("level index not applied");

  property p_console;
    con_load |=> display == {5'h00, $past(con_wdata[18:0])};
  endproperty
  a_console: assert property (p_console) else $error("console entry not shown");

  property p_base_out;
    start && !busy && kind == EAB_K_BIT && eab_decode(instr) == EAB_OP_BASE_TO_INDEX && !con_load
      |=> k_wr && done && k_wdata == {6'h00, $past(r_reg.bit_base_address)};
  endproperty
  a_base_out: assert property (p_base_out) else $error("base not sent to index");

  property p_bit_end;
    r_reg.state == EAB_S_BRD && mem_ack && !alu_write |=> done && cond_vld && !busy;
  endproperty
  a_bit_end: assert property (p_bit_end) else $error("bit operation not reported");

  c_two_level: cover property (r_reg.state == EAB_S_IND && mem_ack && mem_rdata[23]);
  c_bit_write: cover property (r_reg.state == EAB_S_BWR && mem_ack);
  c_branch: cover property (branch_take);
  c_long: cover property (start && kind == EAB_K_LONGBR);
endmodule : eab_unit

// file: testbench/eab_mem_model.sv
/*
  Behavioural main memory that answers the unit's memory port.
  Assumes each request is held until acknowledged and that dly stays steady.
*/
`timescale 1ns/1ps
module eab_mem_model (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Memory port and answer delay in cycles.
  input wire eab_pkg::eab_mem_t mem,
  input wire logic [3:0] dly,
  output logic mem_ack,
  output logic [23:0] mem_rdata
);
  import eab_pkg::*;
  // Word storage covering the whole 18-bit space.
  logic [23:0] store [0:262143];
  // Cycles already waited on the current request.
  logic [3:0] wait_reg;
  // Lets the bench place words before a test.
  function automatic void poke(input logic [17:0] a, input logic [23:0] d);
    store[a] = d;
  endfunction : poke
  // Answer each held request once after dly cycles; between answers the
  // read data toggles so that stale data can never pass for an answer.
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mem_ack <= 1'b0;
      wait_reg <= 4'h0;
      mem_rdata <= 24'h000000;
    end else if (mem_ack || !mem.req) begin
      mem_ack <= 1'b0;
      wait_reg <= 4'h0;
      mem_rdata <= ~mem_rdata;
    end else if (wait_reg < dly) begin
      wait_reg <= wait_reg + 4'h1;
      mem_rdata <= ~mem_rdata;
    end else begin
      mem_ack <= 1'b1;
      mem_rdata <= store[mem.addr];
      if (mem.we) begin
        store[mem.addr] <= mem.wdata;
      end
    end
  end
endmodule : eab_mem_model

// file: testbench/tb_top.sv
/*
  Self-checking bench for the address and bit unit.
  Assumes the memory model beside it and the unit's hand-over contract.
*/
`timescale 1ns/1ps
module tb_top;
  import eab_pkg::*;
  // Inputs of the unit, all valued at time zero.
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0;
  eab_kind_t kind = EAB_K_MEMREF;
  logic [23:0] instr = 24'h000000;
  logic [15:0] pc = 16'h0000;
  eab_idx_t idx = '{i: 24'h000010, j: 24'h000200, k: 24'h03F000};
  logic flag = 1'b1;
  logic con_load = 1'b0;
  logic [23:0] con_wdata = 24'h000000;
  logic [3:0] dly = 4'h0;
  // Outputs of the unit and the memory.
  logic busy, done, cond_vld, branch_take, k_wr, mem_ack;
  logic [17:0] ea;
  logic [3:0] cond;
  logic [23:0] k_wdata, mem_rdata, display;
  eab_mem_t mem;
  // Counters and sticky catchers of single-cycle pulses.
  int n_errors = 0;
  int total_checks = 0;
  logic seen_kwr = 1'b0;
  logic seen_br = 1'b0;
  // Address rows: kind, instruction, program counter, expected address.
  typedef struct packed {
    eab_kind_t k; logic [23:0] ins; logic [15:0] p; logic [17:0] a;
  } eab_ea_row_t;
  // Bit rows: instruction, expected hold, expected condition (F skips it).
  typedef struct packed {logic [23:0] ins; logic h; logic [3:0] c;} eab_bit_row_t;
  eab_ea_row_t ea_rows [8];
  eab_bit_row_t bit_rows [16];
  // The clock inverts every half period of 25 ns.
  always #25 ref_clk = ~ref_clk;
  eab_unit dut (.ref_clk(ref_clk), .rst(rst), .start(start), .kind(kind), .instr(instr),
    .pc(pc), .idx(idx), .flag(flag), .busy(busy), .done(done), .ea(ea), .cond(cond),
    .cond_vld(cond_vld), .branch_take(branch_take), .k_wr(k_wr), .k_wdata(k_wdata),
    .mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .con_load(con_load),
    .con_wdata(con_wdata), .display(display));
  eab_mem_model mm (.ref_clk(ref_clk), .rst(rst), .mem(mem), .dly(dly), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));
  // Pulses are caught as they rise, well before the bench samples.
  always @(posedge k_wr) seen_kwr = 1'b1;
  always @(posedge branch_take) seen_br = 1'b1;
  // Builds a memory-bit instruction with displacement 5.
  function automatic logic [23:0] mk(input logic [10:0] op, input logic [4:0] sel);
    return {op, sel, 8'h05};
  endfunction : mk
  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Issues one request and waits a bounded time for its completion pulse.
  task automatic run(input eab_kind_t k, input logic [23:0] ins);
    int n;
    @(negedge ref_clk);
    kind = k;
    instr = ins;
    start = 1'b1;
    @(negedge ref_clk);
    start = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 200) begin
      @(negedge ref_clk);
      n++;
    end
    chk({23'h0, done}, 24'h000001);
  endtask : run
  // Loads base and hold from the console and lets the registers settle.
  task automatic console(input logic [23:0] d);
    @(negedge ref_clk);
    con_wdata = d;
    con_load = 1'b1;
    @(negedge ref_clk);
    con_load = 1'b0;
    @(negedge ref_clk);
  endtask : console
  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test
  // Watchdog well beyond the hundred-odd cycles the tests need.
  initial begin
    #300000;
    n_errors++;
    finish_test();
  end
  // Main sequence.
  initial begin
    ea_rows = '{'{EAB_K_MEMREF, 24'h001234, 16'h0000, 18'h01234},
      '{EAB_K_MEMREF, 24'h001234, 16'h8000, 18'h09234},
      '{EAB_K_MEMREF, 24'h000005, 16'h8000, 18'h08005},
      '{EAB_K_MEMREF, 24'h047FF0, 16'h0000, 18'h08000},
      '{EAB_K_MEMREF, 24'h087F00, 16'h0000, 18'h08100},
      '{EAB_K_MEMREF, 24'h0C1000, 16'h0000, 18'h00000},
      '{EAB_K_MEMREF, 24'h047FFF, 16'h8000, 18'h1800F},
      '{EAB_K_LONGBR, 24'h0DABCD, 16'h8000, 18'h0ABCD}};
    bit_rows = '{'{24'hE23000, 1'b0, 4'h2}, '{mk(11'h70A, 5'h5), 1'b1, 4'h1},
      '{mk(11'h701, 5'h5), 1'b0, 4'h2}, '{mk(11'h702, 5'h5), 1'b1, 4'h1},
      '{mk(11'h700, 5'h4), 1'b0, 4'h2}, '{mk(11'h703, 5'h4), 1'b1, 4'h1},
      '{mk(11'h704, 5'h5), 1'b0, 4'h2}, '{mk(11'h705, 5'h4), 1'b1, 4'h1},
      '{24'hE20FFF, 1'b0, 4'h2}, '{24'hE22000, 1'b1, 4'h1}, '{24'hE21ABC, 1'b1, 4'h1},
      '{mk(11'h708, 5'h4), 1'b1, 4'h2}, '{mk(11'h709, 5'h0), 1'b1, 4'hF},
      '{mk(11'h706, 5'h4), 1'b1, 4'hF}, '{mk(11'h707, 5'h5), 1'b1, 4'hF},
      '{mk(11'h70B, 5'h4), 1'b1, 4'hF}};
    repeat (8) @(negedge ref_clk);
    rst = 1'b0;
    chk({22'h0, busy, done}, 24'h000000);
    chk(display, 24'h000000);
    $display("test reset finished");
    for (int r = 0; r < 8; r++) begin
      pc = ea_rows[r].p;
      run(ea_rows[r].k, ea_rows[r].ins);
      chk(24'(ea), 24'(ea_rows[r].a));
    end
    $display("test direct addresses finished");
    // A slow memory serves a two-level chain: standard word, then long word.
    dly = 4'h3;
    mm.poke(18'h08100, 24'h912000);
    mm.poke(18'h02010, 24'h43ABCD);
    mm.poke(18'h00005, 24'h00FFFF);
    run(EAB_K_MEMREF, 24'h020100);
    chk({6'h00, ea}, 24'h03ABCD);
    run(EAB_K_LONGBR, 24'h030005);
    chk({6'h00, ea}, 24'h00FFFF);
    $display("test indirect chains finished");
    console(24'h040123);
    chk(display, 24'h040123);
    run(EAB_K_BIT, 24'hE24000);
    chk(display, 24'h07F000);
    run(EAB_K_BIT, 24'hE25000);
    chk(k_wdata, 24'h03F000);
    chk({22'h0, k_wr, cond_vld}, 24'h000002);
    chk({23'h0, seen_kwr}, 24'h000001);
    $display("test base transfers finished");
    // Bit operations on word 0x105 (base 0x100 plus displacement 5).
    console(24'h000100);
    mm.poke(18'h00105, 24'h000020);
    dly = 4'h1;
    for (int r = 0; r < 16; r++) begin
      run(EAB_K_BIT, bit_rows[r].ins);
      chk({23'h0, display[18]}, {23'h0, bit_rows[r].h});
      chk({22'h0, busy, cond_vld}, 24'h000001);
      if (bit_rows[r].c !== 4'hF) begin
        chk({20'h0, cond}, {20'h0, bit_rows[r].c});
      end
    end
    chk(mm.store[18'h00105], 24'h000011);
    chk({23'h0, seen_br}, 24'h000001);
    // An unknown bit code finishes at once and leaves hold and condition alone.
    run(EAB_K_BIT, 24'h000000);
    chk({22'h0, display[18], cond_vld}, 24'h000002);
    $display("test bit operations finished");
    // A second reset in mid-run clears the address and the display.
    @(negedge ref_clk);
    rst = 1'b1;
    @(negedge ref_clk);
    rst = 1'b0;
    chk({6'h00, ea}, 24'h000000);
    chk(display, 24'h000000);
    $display("test second reset finished");
    finish_test();
  end
endmodule : tb_top
